// ===== bench/dss_event_src.sv
// event source model standing in for comparator match logic and profiler
`timescale 1ns/100ps
module dss_event_src
(
  input  wire logic       core_clk,
  input  wire logic       reset,
  input  wire logic [6:0] evReq,
  input  wire logic       profReq,
  output logic      [3:0] compMatch,
  output logic            extEvent,
  output logic            forcedCaptureEvent,
  output logic            traceOverflow,
  output logic            profileTxActive
);
  // events launch on an edge like registered comparator outputs,
  // so each request reaches the block one cycle later and lasts as many cycles as it is held
  always_ff @(posedge core_clk)
  begin
    {profileTxActive, traceOverflow, forcedCaptureEvent, extEvent, compMatch} <= reset ? 8'h00 : {profReq, evReq};
  end
endmodule

// ===== bench/dss_sequencer_sva.sv
// assertion checker for the debug state sequencer event block
`timescale 1ns/100ps
module dss_sequencer_sva
#(
  parameter int NUM_CH = 4
)
(
  input wire logic        core_clk,
  input wire logic        reset,
  input wire logic [15:0] regAddr,
  input wire logic [7:0]  regWrData,
  input wire logic        regWrEn,
  input wire logic        regRdEn,
  input wire logic [7:0]  regRdData_ff,
  input wire logic [3:0]  compMatch,
  input wire logic        extEvent,
  input wire logic        forcedCaptureEvent,
  input wire logic        traceOverflow,
  input wire logic        profileTxActive,
  input wire logic [2:0]  seqStateCode_ff,
  input wire logic        armed_ff,
  input wire logic [7:0]  eventFlags_ff
);
  // ----
  // helpers
  // ----
  logic ctrlWr;
  logic armWr;
  logic flagRd;
  // a control write may arm or disarm, so event checks skip it
  assign ctrlWr = regWrEn && (regAddr == dss_pkg::ADDR_CTRL);
  assign armWr  = ctrlWr && regWrData[dss_pkg::CTRL_ARM_BIT];
  assign flagRd = regRdEn && (regAddr == dss_pkg::ADDR_FLAGS);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);
  // ----
  // properties
  // ----
  arm_enters_one_a: assert property (armWr |=> armed_ff && seqStateCode_ff == 3'h1)
    else $error("arming did not enter the first state");
  arm_clears_a: assert property (armWr && !forcedCaptureEvent |=> eventFlags_ff == 8'h00)
    else $error("arming did not clear the flags");
  arm_forced_a: assert property (armWr && forcedCaptureEvent |=> eventFlags_ff[6])
    else $error("forced flag lost on arming write");
  disarm_hold_a: assert property (!armed_ff && !armWr |=> $stable(eventFlags_ff))
    else $error("flags changed while disarmed");
  flag_sticky_a: assert property (!armWr |=> (eventFlags_ff & $past(eventFlags_ff)) == $past(eventFlags_ff))
    else $error("a set flag was cleared");
  ext_flag_a: assert property (armed_ff && extEvent && !ctrlWr |=> eventFlags_ff[4])
    else $error("external event flag not set");
  ovf_flag_a: assert property (armed_ff && traceOverflow && profileTxActive && !ctrlWr |=> eventFlags_ff[7])
    else $error("overflow flag not set");
  forced_armed_a: assert property (armed_ff && forcedCaptureEvent && !ctrlWr |=> eventFlags_ff[6])
    else $error("forced flag not set while armed");
  flags_read_a: assert property (flagRd |=> regRdData_ff == $past(eventFlags_ff))
    else $error("flag read data mismatch");
endmodule
bind dss_sequencer dss_sequencer_sva #(.NUM_CH(NUM_CH)) u_sva
(
  .core_clk(core_clk), .reset(reset), .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
  .regRdEn(regRdEn), .regRdData_ff(regRdData_ff), .compMatch(compMatch), .extEvent(extEvent),
  .forcedCaptureEvent(forcedCaptureEvent), .traceOverflow(traceOverflow), .profileTxActive(profileTxActive),
  .seqStateCode_ff(seqStateCode_ff), .armed_ff(armed_ff), .eventFlags_ff(eventFlags_ff)
);

// ===== bench/test_dss_sequencer.sv
// self-checking testbench for the debug state sequencer event block
`timescale 1ns/100ps
module test_dss_sequencer;
  // ----
  // signals
  // ----
  logic        core_clk;
  logic        reset;
  logic [15:0] regAddr;
  logic [7:0]  regWrData;
  logic        regWrEn;
  logic        regRdEn;
  logic [7:0]  regRdData_ff;
  logic [3:0]  compMatch;
  logic        extEvent;
  logic        forcedCaptureEvent;
  logic        traceOverflow;
  logic        profileTxActive;
  logic [2:0]  seqStateCode_ff;
  logic        armed_ff;
  logic [7:0]  eventFlags_ff;
  logic [6:0]  evReq;
  logic        profReq;
  logic [7:0]  rdVal;
  int          failures;
  int          comparisons;
  // next state per field code 0..3, in State2 and State3
  localparam logic [2:0] s2Exp [4] = '{3'h2, 3'h1, 3'h3, 3'h4};
  localparam logic [2:0] s3Exp [4] = '{3'h3, 3'h1, 3'h2, 3'h4};
  // ----
  // instances
  // ----
  dss_sequencer #(.NUM_CH(4)) DUT
  (
    .core_clk(core_clk), .reset(reset), .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
    .regRdEn(regRdEn), .regRdData_ff(regRdData_ff), .compMatch(compMatch), .extEvent(extEvent),
    .forcedCaptureEvent(forcedCaptureEvent), .traceOverflow(traceOverflow), .profileTxActive(profileTxActive),
    .seqStateCode_ff(seqStateCode_ff), .armed_ff(armed_ff), .eventFlags_ff(eventFlags_ff)
  );
  dss_event_src src
  (
    .core_clk(core_clk), .reset(reset), .evReq(evReq), .profReq(profReq), .compMatch(compMatch),
    .extEvent(extEvent), .forcedCaptureEvent(forcedCaptureEvent), .traceOverflow(traceOverflow),
    .profileTxActive(profileTxActive)
  );
  // 50 ns period
  always #25 core_clk = ~core_clk;
  // ----
  // shared tasks
  // ----
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge core_clk);
    regWrEn   <= 1'b1;
    regAddr   <= a;
    regWrData <= d;
    @(posedge core_clk);
    regWrEn <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rdchk(input string what, input logic [15:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    regRdEn <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRdEn <= 1'b0;
    #1;
    chk(what, exp, regRdData_ff);
  endtask
  // one cycle of events, judged after the block has taken them
  task automatic pulse(input logic [6:0] v);
    @(posedge core_clk);
    evReq <= v;
    @(posedge core_clk);
    evReq <= 7'h00;
    @(posedge core_clk);
    #1;
  endtask
  task automatic seq_case(input logic [15:0] a, input logic [7:0] v, input logic [3:0] go, input logic [3:0] hit,
                          input logic [2:0] exp);
    wr(dss_pkg::ADDR_CTRL, 8'h00);
    wr(a, v);
    wr(dss_pkg::ADDR_CTRL, 8'h01);
    pulse({3'h0, go});
    pulse({3'h0, hit});
    chk("state", {5'h00, exp}, {5'h00, seqStateCode_ff});
    chk("armed", 8'h01, {7'h00, armed_ff});
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_reset;
    rdchk("state2", dss_pkg::ADDR_STATE2, dss_pkg::RST_BYTE);
    rdchk("state3", dss_pkg::ADDR_STATE3, dss_pkg::RST_BYTE);
    rdchk("flags", dss_pkg::ADDR_FLAGS, 8'h00);
    rdchk("unmapped", 16'h01ff, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_regs;
    wr(dss_pkg::ADDR_STATE2, 8'he4);
    wr(dss_pkg::ADDR_STATE3, 8'h1b);
    wr(dss_pkg::ADDR_FLAGS, 8'hff);
    rdchk("state2", dss_pkg::ADDR_STATE2, 8'he4);
    rdchk("state3", dss_pkg::ADDR_STATE3, 8'h1b);
    rdchk("flags", dss_pkg::ADDR_FLAGS, 8'h00);
    wr(dss_pkg::ADDR_CTRL, 8'h01);
    wr(dss_pkg::ADDR_STATE2, 8'h55);
    rdchk("state2", dss_pkg::ADDR_STATE2, 8'he4);
    wr(dss_pkg::ADDR_CTRL, 8'h00);
    @(posedge core_clk);
    profReq <= 1'b1;
    wr(dss_pkg::ADDR_STATE3, 8'h55);
    rdchk("state3", dss_pkg::ADDR_STATE3, 8'h1b);
    profReq <= 1'b0;
    wr(dss_pkg::ADDR_STATE3, 8'h55);
    rdchk("state3", dss_pkg::ADDR_STATE3, 8'h55);
    wr(dss_pkg::ADDR_COMP_EN, 8'h0f);
    wr(dss_pkg::ADDR_STATE1, 8'h09);
    $display("test registers done");
  endtask
  task automatic t_trans;
    for (int i = 0; i < 4; i++)
    begin
      seq_case(dss_pkg::ADDR_STATE2, 8'(i << 2), 4'h1, 4'h2, s2Exp[i]);
      seq_case(dss_pkg::ADDR_STATE3, 8'(i << 4), 4'h2, 4'h4, s3Exp[i]);
    end
    $display("test transitions done");
  endtask
  task automatic t_prio;
    seq_case(dss_pkg::ADDR_STATE2, 8'h31, 4'h1, 4'hd, 3'h4);
    chk("flags", 8'h0d, eventFlags_ff);
    wr(dss_pkg::ADDR_CTRL, 8'h00);
    wr(dss_pkg::ADDR_COMP_EN, 8'h0e);
    wr(dss_pkg::ADDR_CTRL, 8'h01);
    pulse(7'h01);
    chk("state", 8'h01, {5'h00, seqStateCode_ff});
    chk("flags", 8'h00, eventFlags_ff);
    wr(dss_pkg::ADDR_CTRL, 8'h00);
    wr(dss_pkg::ADDR_COMP_EN, 8'h0f);
    $display("test priority done");
  endtask
  task automatic t_ext;
    wr(dss_pkg::ADDR_STATE2, 8'h80);
    wr(dss_pkg::ADDR_CTRL, 8'h05);
    pulse(7'h01);
    pulse(7'h08);
    chk("state", 8'h02, {5'h00, seqStateCode_ff});
    pulse(7'h10);
    chk("state", 8'h03, {5'h00, seqStateCode_ff});
    rdchk("status", dss_pkg::ADDR_STATUS, 8'h03);
    rdchk("ctrl", dss_pkg::ADDR_CTRL, 8'h05);
    chk("flags", 8'h19, eventFlags_ff);
    wr(dss_pkg::ADDR_CTRL, 8'h00);
    seq_case(dss_pkg::ADDR_CTRL, 8'h00, 4'h1, 4'h8, 3'h3);
    $display("test external done");
  endtask
  task automatic t_flags;
    wr(dss_pkg::ADDR_CTRL, 8'h00);
    pulse(7'h7f);
    chk("flags", 8'h09, eventFlags_ff);
    wr(dss_pkg::ADDR_CTRL, 8'h01);
    #1;
    chk("flags", 8'h00, eventFlags_ff);
    pulse(7'h20);
    pulse(7'h40);
    chk("flags", 8'h40, eventFlags_ff);
    profReq <= 1'b1;
    pulse(7'h40);
    pulse(7'h10);
    profReq <= 1'b0;
    rdchk("flags", dss_pkg::ADDR_FLAGS, 8'hd0);
    wr(dss_pkg::ADDR_CTRL, 8'h00);
    @(posedge core_clk);
    evReq <= 7'h20;
    @(posedge core_clk);
    evReq     <= 7'h00;
    regWrEn   <= 1'b1;
    regAddr   <= dss_pkg::ADDR_CTRL;
    regWrData <= 8'h01;
    @(posedge core_clk);
    regWrEn <= 1'b0;
    #1;
    chk("flags", 8'h40, eventFlags_ff);
    $display("test flags done");
  endtask
  // ----
  // run control
  // ----
  task automatic wrap_up;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // the tests need about 250 cycles; the 5000-cycle limit allows about twenty times that
  initial
  begin
    #250000;
    failures++;
    $display("watchdog expired");
    wrap_up;
  end
  initial
  begin
    core_clk = 1'b0;
    reset = 1'b1;
    regAddr = 16'h0000;
    regWrData = 8'h00;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    evReq = 7'h00;
    profReq = 1'b0;
    failures = 0;
    comparisons = 0;
    repeat (20) @(posedge core_clk);
    reset <= 1'b0;
    t_reset;
    t_regs;
    t_trans;
    t_prio;
    t_ext;
    t_flags;
    wrap_up;
  end
endmodule

// ===== core/dss_next_state.sv
// next-state selector: highest matching channel with a code other than none picks the transition
`timescale 1ns/100ps
module dss_next_state
(
  dss_sel_if.sel selIf
);

  // ---------------------------------------------------------------
  // transition decode
  // ---------------------------------------------------------------
  // later channels with a code other than none overwrite earlier ones, so the highest such channel wins
  always_comb
  begin
    logic [1:0] code;
    code = dss_pkg::SEL_NONE;
    for (int ch = 0; ch < dss_pkg::NUM_CH; ch++)
    begin
      if (selIf.match[ch] && (selIf.selByte[ch*2 +: 2] != dss_pkg::SEL_NONE))
      begin
        code = selIf.selByte[ch*2 +: 2];
      end
    end
    selIf.hit      = (code != dss_pkg::SEL_NONE);
    selIf.nxtState = selIf.curState;
    case (selIf.curState)
      dss_pkg::DSS_ST_ONE:
      begin
        case (code)
          dss_pkg::SEL_A:     selIf.nxtState = dss_pkg::DSS_ST_TWO;
          dss_pkg::SEL_B:     selIf.nxtState = dss_pkg::DSS_ST_THREE;
          dss_pkg::SEL_FINAL: selIf.nxtState = dss_pkg::DSS_ST_FINAL;
          default:            selIf.nxtState = selIf.curState;
        endcase
      end
      dss_pkg::DSS_ST_TWO:
      begin
        case (code)
          dss_pkg::SEL_A:     selIf.nxtState = dss_pkg::DSS_ST_ONE;
          dss_pkg::SEL_B:     selIf.nxtState = dss_pkg::DSS_ST_THREE;
          dss_pkg::SEL_FINAL: selIf.nxtState = dss_pkg::DSS_ST_FINAL;
          default:            selIf.nxtState = selIf.curState;
        endcase
      end
      dss_pkg::DSS_ST_THREE:
      begin
        case (code)
          dss_pkg::SEL_A:     selIf.nxtState = dss_pkg::DSS_ST_ONE;
          dss_pkg::SEL_B:     selIf.nxtState = dss_pkg::DSS_ST_TWO;
          dss_pkg::SEL_FINAL: selIf.nxtState = dss_pkg::DSS_ST_FINAL;
          default:            selIf.nxtState = selIf.curState;
        endcase
      end
      default:
      begin
        selIf.nxtState = selIf.curState; // idle and final hold
      end
    endcase
  end

endmodule

// ===== core/dss_pkg.sv
// shared constants and types for the debug state sequencer event block
package dss_pkg;

  // ---------------------------------------------------------------
  // register map (byte addresses on the plain register port)
  // ---------------------------------------------------------------
  localparam int          ADDR_W        = 16;
  localparam int          DATA_W        = 8;
  localparam logic [15:0] ADDR_CTRL     = 16'h0100;
  localparam logic [15:0] ADDR_COMP_EN  = 16'h0101;
  localparam logic [15:0] ADDR_STATE1   = 16'h0107;
  localparam logic [15:0] ADDR_STATE2   = 16'h0108;
  localparam logic [15:0] ADDR_STATE3   = 16'h0109;
  localparam logic [15:0] ADDR_FLAGS    = 16'h010a;
  localparam logic [15:0] ADDR_STATUS   = 16'h010b;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int CTRL_ARM_BIT    = 0;
  localparam int CTRL_EXTSEL_LSB = 1;
  localparam int FLAG_OVF_BIT    = 7;
  localparam int FLAG_FORCED_BIT = 6;
  localparam int FLAG_EXT_BIT    = 4;
  localparam int FLAG_HIT_LSB    = 0;
  localparam int STAT_PTX_BIT    = 4;
  localparam int SEL_W           = 2;
  localparam int NUM_CH          = 4;

  // ---------------------------------------------------------------
  // encodings and reset values
  // ---------------------------------------------------------------
  localparam logic [1:0] EXTSEL_EXT_EVENT = 2'h2;
  localparam logic [1:0] SEL_NONE         = 2'h0;
  localparam logic [1:0] SEL_A            = 2'h1;
  localparam logic [1:0] SEL_B            = 2'h2;
  localparam logic [1:0] SEL_FINAL        = 2'h3;
  localparam logic [7:0] RST_BYTE         = 8'h00;
  localparam logic [3:0] RST_COMP_EN      = 4'h0;

  // sequencer state codes as shown to software
  typedef enum logic [2:0] {
    DSS_ST_IDLE  = 3'b000,
    DSS_ST_ONE   = 3'b001,
    DSS_ST_TWO   = 3'b010,
    DSS_ST_THREE = 3'b011,
    DSS_ST_FINAL = 3'b100
  } dss_state_e;

endpackage

// ===== core/dss_sel_if.sv
// interface between the sequencer core and its next-state selector
`timescale 1ns/100ps
interface dss_sel_if;
  dss_pkg::dss_state_e curState;
  logic [7:0]          selByte;
  logic [3:0]          match;
  logic                hit;
  dss_pkg::dss_state_e nxtState;

  modport core
  (
    output curState,
    output selByte,
    output match,
    input  hit,
    input  nxtState
  );

  modport sel
  (
    input  curState,
    input  selByte,
    input  match,
    output hit,
    output nxtState
  );
endinterface

// ===== core/dss_sequencer.sv
// debug state sequencer: state control registers, arming and event flags
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/100ps

// Function
// - state control writes only disarmed, not profiling
// - State2 register holds four 2-bit channel fields
// - State2 codes: none, State1, State3, Final
// - State3 codes: none, State1, State2, Final
// - State3 register uses same field layout
// - extsel 10 routes external event to channel3
// - highest matching channel with a code other than none wins simultaneous matches
// - disabled comparator produces no match
// - event flag register is read-only
// - flags except forced set only while armed
// - forced flag set armed or arming write
// - flags cleared only by arming, otherwise kept
// - each flag sets independently of others
// - bit 6 is forced capture flag
// - bit 4 is external event flag
// - bits 3-0 are per-channel hit flags
// - overflow flag set on profiling buffer overflow
// - arming enters State1, code 001
// - State1 codes: none, State2, State3, Final
module dss_sequencer
#(
  parameter int NUM_CH = 4
)
(
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire logic [15:0] regAddr,
  input  wire logic [7:0]  regWrData,
  input  wire logic        regWrEn,
  input  wire logic        regRdEn,
  output logic      [7:0]  regRdData_ff,
  input  wire logic [3:0]  compMatch,
  input  wire logic        extEvent,
  input  wire logic        forcedCaptureEvent,
  input  wire logic        traceOverflow,
  input  wire logic        profileTxActive,
  output logic      [2:0]  seqStateCode_ff,
  output logic             armed_ff,
  output logic      [7:0]  eventFlags_ff
);

  // ---------------------------------------------------------------
  // parameter check
  // ---------------------------------------------------------------
  // the register fields are laid out for exactly four channels
  if (NUM_CH != dss_pkg::NUM_CH)
  begin : g_badChannels
    $error("dss_sequencer: NUM_CH must be 4");
  end

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic                [1:0] extSelect_ff;
  logic                [3:0] compOn_ff;
  logic                [7:0] state1Ctl_ff;
  logic                [7:0] state2Ctl_ff;
  logic                [7:0] state3Ctl_ff;
  dss_pkg::dss_state_e       state_ff;
  dss_pkg::dss_state_e       nxt_state;
  logic                [7:0] nxt_eventFlags;
  logic                [7:0] nxt_regRdData;
  logic                [3:0] gatedMatch;
  logic                [3:0] seqMatch;
  logic                      wrCtrl;
  logic                      wrCompEn;
  logic                      wrState1;
  logic                      wrState2;
  logic                      wrState3;
  logic                      ctlWriteOk;
  logic                      armWrite;
  logic                      disarmWrite;
  logic                      extRouted;
  logic                      flagSetOk;

  dss_sel_if selIf ();

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  // one-cycle strobes qualified by the exact byte address
  assign wrCtrl   = regWrEn && (regAddr == dss_pkg::ADDR_CTRL);
  assign wrCompEn = regWrEn && (regAddr == dss_pkg::ADDR_COMP_EN);
  assign wrState1 = regWrEn && (regAddr == dss_pkg::ADDR_STATE1);
  assign wrState2 = regWrEn && (regAddr == dss_pkg::ADDR_STATE2);
  assign wrState3 = regWrEn && (regAddr == dss_pkg::ADDR_STATE3);

  // configuration is frozen during a session or a profiling transfer
  assign ctlWriteOk = !armed_ff && !profileTxActive;

  // any write of a one to the arm bit starts a fresh session
  assign armWrite    = wrCtrl && regWrData[dss_pkg::CTRL_ARM_BIT];
  assign disarmWrite = wrCtrl && !regWrData[dss_pkg::CTRL_ARM_BIT];

  // ---------------------------------------------------------------
  // arm control
  // ---------------------------------------------------------------
  // arm is always writable so software can stop a runaway session
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      armed_ff <= 1'b0;
    end
    else if (wrCtrl)
    begin
      armed_ff <= regWrData[dss_pkg::CTRL_ARM_BIT];
    end
  end

  // ---------------------------------------------------------------
  // event source and comparator enable configuration
  // ---------------------------------------------------------------
  // same lockout as the state control registers
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      extSelect_ff <= 2'h0;
    end
    else if (wrCtrl && ctlWriteOk)
    begin
      extSelect_ff <= regWrData[dss_pkg::CTRL_EXTSEL_LSB +: 2];
    end
  end

  // comparator enables, one bit per channel
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      compOn_ff <= dss_pkg::RST_COMP_EN;
    end
    else if (wrCompEn && ctlWriteOk)
    begin
      compOn_ff <= regWrData[3:0];
    end
  end

  // ---------------------------------------------------------------
  // state control registers
  // ---------------------------------------------------------------
  // a blocked write simply falls through, no error is reported
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      state1Ctl_ff <= dss_pkg::RST_BYTE;
    end
    else if (wrState1 && ctlWriteOk)
    begin
      state1Ctl_ff <= regWrData;
    end
  end

  // four 2-bit fields, channel n at bits 2n+1..2n
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      state2Ctl_ff <= dss_pkg::RST_BYTE;
    end
    else if (wrState2 && ctlWriteOk)
    begin
      state2Ctl_ff <= regWrData;
    end
  end

  // identical field layout to the State2 register
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      state3Ctl_ff <= dss_pkg::RST_BYTE;
    end
    else if (wrState3 && ctlWriteOk)
    begin
      state3Ctl_ff <= regWrData;
    end
  end

  // ---------------------------------------------------------------
  // match conditioning
  // ---------------------------------------------------------------
  // a switched-off comparator never reaches flags or sequencer
  for (genvar ch = 0; ch < NUM_CH; ch++)
  begin : g_gate
    assign gatedMatch[ch] = compMatch[ch] && compOn_ff[ch];
  end

  // channel 3 of the sequencer may listen to the external event
  assign extRouted = (extSelect_ff == dss_pkg::EXTSEL_EXT_EVENT);
  assign seqMatch  = {extRouted ? extEvent : gatedMatch[3], gatedMatch[2:0]};

  // ---------------------------------------------------------------
  // next-state selection
  // ---------------------------------------------------------------
  // pick the control byte that belongs to the present state
  always_comb
  begin
    selIf.curState = state_ff;
    selIf.match    = seqMatch;
    case (state_ff)
      dss_pkg::DSS_ST_ONE:   selIf.selByte = state1Ctl_ff;
      dss_pkg::DSS_ST_TWO:   selIf.selByte = state2Ctl_ff;
      dss_pkg::DSS_ST_THREE: selIf.selByte = state3Ctl_ff;
      default:               selIf.selByte = dss_pkg::RST_BYTE;
    endcase
  end

  dss_next_state u_nextState
  (
    .selIf (selIf.sel)
  );

  // ---------------------------------------------------------------
  // sequencer state
  // ---------------------------------------------------------------
  // arming wins over any match in the same cycle
  always_comb
  begin
    nxt_state = state_ff;
    if (armWrite)
    begin
      nxt_state = dss_pkg::DSS_ST_ONE;
    end
    else if (armed_ff && !disarmWrite && selIf.hit)
    begin
      nxt_state = selIf.nxtState;
    end
  end

  // disarming by software keeps the last state for inspection
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      state_ff <= dss_pkg::DSS_ST_IDLE;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  // state code output mirrors the sequencer register
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      seqStateCode_ff <= dss_pkg::DSS_ST_IDLE;
    end
    else
    begin
      seqStateCode_ff <= nxt_state;
    end
  end

  // ---------------------------------------------------------------
  // event flags
  // ---------------------------------------------------------------
  // flags other than forced collect events only in a running session, never in a control write cycle
  assign flagSetOk = armed_ff && !wrCtrl;

  // an arming write clears, but a same-cycle forced capture event still sets
  always_comb
  begin
    nxt_eventFlags = armWrite ? dss_pkg::RST_BYTE : eventFlags_ff;
    // each flag ORs in its own event, no flag masks another
    if (flagSetOk || armWrite)
    begin
      nxt_eventFlags[dss_pkg::FLAG_HIT_LSB +: 4] =
        nxt_eventFlags[dss_pkg::FLAG_HIT_LSB +: 4] | (flagSetOk ? gatedMatch : 4'h0);
    end
    if (flagSetOk && extEvent)
    begin
      nxt_eventFlags[dss_pkg::FLAG_EXT_BIT] = 1'b1;
    end
    if (flagSetOk && traceOverflow && profileTxActive)
    begin
      nxt_eventFlags[dss_pkg::FLAG_OVF_BIT] = 1'b1;
    end
    // the forced flag also catches the very arming cycle
    if (forcedCaptureEvent && (flagSetOk || armWrite))
    begin
      nxt_eventFlags[dss_pkg::FLAG_FORCED_BIT] = 1'b1;
    end
    nxt_eventFlags[5] = 1'b0; // unused bit reads zero
  end

  // no register write path reaches these bits
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      eventFlags_ff <= dss_pkg::RST_BYTE;
    end
    else
    begin
      eventFlags_ff <= nxt_eventFlags;
    end
  end

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  // data valid only in the cycle after the strobe, zero otherwise
  always_comb
  begin
    nxt_regRdData = dss_pkg::RST_BYTE;
    if (regRdEn)
    begin
      case (regAddr)
        dss_pkg::ADDR_CTRL:    nxt_regRdData = {5'h00, extSelect_ff, armed_ff};
        dss_pkg::ADDR_COMP_EN: nxt_regRdData = {4'h0, compOn_ff};
        dss_pkg::ADDR_STATE1:  nxt_regRdData = state1Ctl_ff;
        dss_pkg::ADDR_STATE2:  nxt_regRdData = state2Ctl_ff;
        dss_pkg::ADDR_STATE3:  nxt_regRdData = state3Ctl_ff;
        dss_pkg::ADDR_FLAGS:   nxt_regRdData = eventFlags_ff;
        dss_pkg::ADDR_STATUS:  nxt_regRdData = {3'h0, profileTxActive, 1'b0, state_ff};
        default:               nxt_regRdData = dss_pkg::RST_BYTE;
      endcase
    end
  end

  // registered read data keeps the output straight from a flop
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      regRdData_ff <= dss_pkg::RST_BYTE;
    end
    else
    begin
      regRdData_ff <= nxt_regRdData;
    end
  end

endmodule
